// *** shared/rtd_consts.svh ***
// Register indices, field positions, masks, reset values and response codes
`ifndef RTD_CONSTS_SVH
`define RTD_CONSTS_SVH
`define RTD_IDX_DRV      6'h28
`define RTD_IDX_AMP      6'h29
`define RTD_IDX_CON      6'h2a
`define RTD_IDX_LOAD     6'h2b
`define RTD_IDX_STAT     6'h30
`define RTD_DRV_INV2     7
`define RTD_DRV_INV1     6
`define RTD_DRV_EN       3
`define RTD_DRV_MASK     8'hcf
`define RTD_AMP_MASK     8'hdf
`define RTD_CON_MAX      3
`define RTD_CON_INV      2
`define RTD_RST_DRV      8'h00
`define RTD_RST_AMP      8'h00
`define RTD_RST_CON      8'h00
`define RTD_RST_LOAD     8'h00
`define RTD_RESP_OKAY    2'h0
`define RTD_RESP_SLVERR  2'h2
`endif

// *** shared/rtd_pkg.sv ***
// Types shared by the transmitter driver configuration block
package rtd_pkg;
  typedef enum logic [2:0] {
    RTD_CM_HIZ  = 3'h0,
    RTD_CM_LOW  = 3'h1,
    RTD_CM_HIGH = 3'h2,
    RTD_CM_BAD3 = 3'h3,
    RTD_CM_OD   = 3'h4,
    RTD_CM_PP   = 3'h5,
    RTD_CM_BAD6 = 3'h6,
    RTD_CM_PPX  = 3'h7
  } rtd_clk_mode_type;
  typedef enum logic [1:0] {
    RTD_SRC_NONE = 2'h0,
    RTD_SRC_ENV  = 2'h1,
    RTD_SRC_EXT  = 2'h2,
    RTD_SRC_RSV  = 2'h3
  } rtd_src_type;
  typedef enum logic [2:0] {
    RTD_OS_IDLE  = 3'b001,
    RTD_OS_WAIT  = 3'b010,
    RTD_OS_BOOST = 3'b100
  } rtd_os_state_type;
endpackage : rtd_pkg

// *** shared/rtd_reg_if.sv ***
// Register access carrier between bus slave and register bank
interface rtd_reg_if;
  logic       wrEn;
  logic [5:0] wrIdx;
  logic [7:0] wrData;
  logic       wrHit;
  logic [5:0] rdIdx;
  logic [7:0] rdData;
  logic       rdHit;
  modport slave (output wrEn, wrIdx, wrData, rdIdx, input wrHit, rdData, rdHit);
  modport bank  (input wrEn, wrIdx, wrData, rdIdx, output wrHit, rdData, rdHit);
endinterface : rtd_reg_if

// *** core/rtd_axil_slave.sv ***
// AXI4-Lite slave front end for the driver register bank
module rtd_axil_slave
  import rtd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstN,
  // AXI4-Lite
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  // Register bank side
  rtd_reg_if.slave        regs
);
`include "rtd_consts.svh"
  logic       awHaveQ, wHaveQ, rdPendQ, strbQ;
  logic [5:0] awIdxQ, arIdxQ;
  logic [7:0] wDataQ;
  logic       fire;
  assign fire        = awHaveQ && wHaveQ && !bvalid;
  assign regs.wrEn   = fire && strbQ;
  assign regs.wrIdx  = awIdxQ;
  assign regs.wrData = wDataQ;
  assign regs.rdIdx  = arIdxQ;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHaveQ <= 1'b0;
      wHaveQ  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RTD_RESP_OKAY;
      awIdxQ  <= 6'h00;
      wDataQ  <= 8'h00;
      strbQ   <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHaveQ <= 1'b1;
        awready <= 1'b0;
        awIdxQ  <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        wHaveQ <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata[7:0];
        strbQ  <= wstrb[0];
      end
      if (fire) begin
        awHaveQ <= 1'b0;
        wHaveQ  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= regs.wrHit ? `RTD_RESP_OKAY : `RTD_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b1;
      rdPendQ <= 1'b0;
      arIdxQ  <= 6'h00;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RTD_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rdPendQ <= 1'b1;
        arIdxQ  <= araddr[7:2];
      end
      if (rdPendQ) begin
        rdPendQ <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h00_0000, regs.rdData};
        rresp   <= regs.rdHit ? `RTD_RESP_OKAY : `RTD_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : rtd_axil_slave

// *** core/rtd_pin_drive.sv ***
// One transmitter output stage: mode, enable and polarity
module rtd_pin_drive
  import rtd_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Control
  input  wire rtd_clk_mode_type mode,
  input  wire logic             enable,
  input  wire logic             invert,
  input  wire logic             level,
  // Pin
  output logic                  pinOut,
  output logic                  pinOe
);
  logic d;
  assign d = level ^ invert;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else if (!enable) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      case (mode)
        RTD_CM_LOW: begin
          pinOut <= 1'b0;
          pinOe  <= 1'b1;
        end
        RTD_CM_HIGH: begin
          pinOut <= 1'b1;
          pinOe  <= 1'b1;
        end
        RTD_CM_OD: begin
          // Open drain only ever pulls low
          pinOut <= 1'b0;
          pinOe  <= ~d;
        end
        RTD_CM_PP, RTD_CM_PPX: begin
          pinOut <= d;
          pinOe  <= 1'b1;
        end
        default: begin
          // Unsupported codes float the pin rather than guess
          pinOut <= 1'b0;
          pinOe  <= 1'b0;
        end
      endcase
    end
  end
endmodule : rtd_pin_drive

// *** core/rtd_top.sv ***
// Transmitter driver configuration bank with modulation and output stages
// Operation
// - Bit 7 of the driver mode register inverts the second driver output.
// - Bit 6 of the driver mode register inverts the first driver output.
// - Both driver outputs are enabled together only while bit 3 of the driver mode register is one.
// - The three-bit clock mode field picks open drain, push-pull, high impedance, fixed high or fixed low.
// - Bits 7 to 6 of the amplitude register pick one of four increasing carrier level reductions.
// - Bit 3 of the transmit control register forces maximum carrier and overrides the level trim.
// - Bit 2 of the transmit control register inverts the selected modulation signal.
// - The modulation source field picks none, internal envelope or external input; code 3 is reserved.
// - Bits 7 to 4 of transmit control give the overshoot extra modulation length in carrier clocks.
// - Bits 7 to 4 of the load register give the first overshoot timer used with the overshoot length.
// - Bits 4 to 0 of the amplitude register set the residual carrier level during modulation.
// - Bits 3 to 0 of the load register hold the load current trim for the driver.
module rtd_top
  import rtd_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Transmit timing and modulation sources
  input  wire logic        carrierLevel,
  input  wire logic        carrierTick,
  input  wire logic        internalTransmitEnvelope,
  input  wire logic        externalSignalInput,
  // Driver pins
  output logic             firstDriverOut,
  output logic             firstDriverOe,
  output logic             secondDriverOut,
  output logic             secondDriverOe,
  // Analog settings
  output logic             carrierMaxQ,
  output logic [1:0]       carrierLevelTrimQ,
  output logic [4:0]       residualCarrierQ,
  output logic [3:0]       loadCurrentTrimQ,
  output logic             modulationQ,
  output logic             overshootActiveQ
);
`include "rtd_consts.svh"

  // Reset release, two stages
  logic rstMetaQ, rstN;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMetaQ <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstN     <= rstMetaQ;
    end
  end

  rtd_reg_if regs ();

  rtd_axil_slave u_slave (
    .clk     (sys_clk),
    .rstN    (rstN),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs)
  );

  // Register bank
  logic [7:0] driverOutputModeQ;
  logic [7:0] carrierAmplitudeQ;
  logic [7:0] transmitControlQ;
  logic [7:0] loadCurrentOvershootQ;
  logic [7:0] statusWord;
  rtd_os_state_type osStateQ;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      driverOutputModeQ     <= `RTD_RST_DRV;
      carrierAmplitudeQ     <= `RTD_RST_AMP;
      transmitControlQ      <= `RTD_RST_CON;
      loadCurrentOvershootQ <= `RTD_RST_LOAD;
    end else if (regs.wrEn) begin
      case (regs.wrIdx)
        `RTD_IDX_DRV:  driverOutputModeQ     <= regs.wrData & `RTD_DRV_MASK;
        `RTD_IDX_AMP:  carrierAmplitudeQ     <= regs.wrData & `RTD_AMP_MASK;
        `RTD_IDX_CON:  transmitControlQ      <= regs.wrData;
        `RTD_IDX_LOAD: loadCurrentOvershootQ <= regs.wrData;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (regs.wrIdx)
      `RTD_IDX_DRV, `RTD_IDX_AMP, `RTD_IDX_CON, `RTD_IDX_LOAD, `RTD_IDX_STAT: regs.wrHit = 1'b1;
      default: regs.wrHit = 1'b0;
    endcase
  end

  always_comb begin
    regs.rdHit = 1'b1;
    case (regs.rdIdx)
      `RTD_IDX_DRV:  regs.rdData = driverOutputModeQ;
      `RTD_IDX_AMP:  regs.rdData = carrierAmplitudeQ;
      `RTD_IDX_CON:  regs.rdData = transmitControlQ;
      `RTD_IDX_LOAD: regs.rdData = loadCurrentOvershootQ;
      `RTD_IDX_STAT: regs.rdData = statusWord;
      default: begin
        regs.rdHit  = 1'b0;
        regs.rdData = 8'h00;
      end
    endcase
  end

  // Field views
  logic             secondOutputInvert, firstOutputInvert, driverOutputsEnable;
  rtd_clk_mode_type driverClockMode;
  logic             carrierMax, modulationInvert;
  rtd_src_type      modulationSourceSelect;
  logic [3:0]       overshootLength, overshootFirstTimer;
  logic             clockModeBad;
  assign secondOutputInvert     = driverOutputModeQ[`RTD_DRV_INV2];
  assign firstOutputInvert      = driverOutputModeQ[`RTD_DRV_INV1];
  assign driverOutputsEnable    = driverOutputModeQ[`RTD_DRV_EN];
  assign driverClockMode        = rtd_clk_mode_type'(driverOutputModeQ[2:0]);
  assign carrierMax             = transmitControlQ[`RTD_CON_MAX];
  assign modulationInvert       = transmitControlQ[`RTD_CON_INV];
  assign modulationSourceSelect = rtd_src_type'(transmitControlQ[1:0]);
  assign overshootLength        = transmitControlQ[7:4];
  assign overshootFirstTimer    = loadCurrentOvershootQ[7:4];
  // Flags a write of a forbidden code; the stages float the pins for it
  assign clockModeBad = (driverClockMode == RTD_CM_BAD3) || (driverClockMode == RTD_CM_BAD6);
  assign statusWord   = {5'h00, clockModeBad, overshootActiveQ, modulationQ};

  // Modulation source and polarity
  logic modSource, modSignal, modPrevQ;
  always_comb begin
    case (modulationSourceSelect)
      RTD_SRC_ENV: modSource = internalTransmitEnvelope;
      RTD_SRC_EXT: modSource = externalSignalInput;
      default:     modSource = 1'b0;
    endcase
  end
  assign modSignal = modSource ^ modulationInvert;

  // Overshoot sequencer, counted in carrier clocks
  logic [3:0] osCntQ;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      osStateQ <= RTD_OS_IDLE;
      osCntQ   <= 4'h0;
      modPrevQ <= 1'b0;
    end else begin
      modPrevQ <= modSignal;
      case (osStateQ)
        RTD_OS_IDLE: begin
          if (modSignal && !modPrevQ && overshootLength != 4'h0) begin
            if (overshootFirstTimer != 4'h0) begin
              osStateQ <= RTD_OS_WAIT;
              osCntQ   <= overshootFirstTimer;
            end else begin
              osStateQ <= RTD_OS_BOOST;
              osCntQ   <= overshootLength;
            end
          end
        end
        RTD_OS_WAIT: begin
          if (carrierTick) begin
            if (osCntQ == 4'h1) begin
              osStateQ <= RTD_OS_BOOST;
              osCntQ   <= overshootLength;
            end else begin
              osCntQ <= osCntQ - 4'h1;
            end
          end
        end
        RTD_OS_BOOST: begin
          if (carrierTick) begin
            if (osCntQ == 4'h1) begin
              osStateQ <= RTD_OS_IDLE;
            end else begin
              osCntQ <= osCntQ - 4'h1;
            end
          end
        end
        default: begin
          osStateQ <= RTD_OS_IDLE;
        end
      endcase
    end
  end

  // Registered analog settings and modulation
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      carrierMaxQ       <= 1'b0;
      carrierLevelTrimQ <= 2'h0;
      residualCarrierQ  <= 5'h00;
      loadCurrentTrimQ  <= 4'h0;
      modulationQ       <= 1'b0;
      overshootActiveQ  <= 1'b0;
    end else begin
      carrierMaxQ       <= carrierMax;
      // Override wins: trim is zeroed rather than left to analog priority
      carrierLevelTrimQ <= carrierMax ? 2'h0 : carrierAmplitudeQ[7:6];
      residualCarrierQ  <= carrierAmplitudeQ[4:0];
      loadCurrentTrimQ  <= loadCurrentOvershootQ[3:0];
      modulationQ       <= modSignal || (osStateQ == RTD_OS_BOOST);
      overshootActiveQ  <= (osStateQ == RTD_OS_BOOST);
    end
  end

  // Output stages
  rtd_pin_drive u_first (
    .clk    (sys_clk),
    .rstN   (rstN),
    .mode   (driverClockMode),
    .enable (driverOutputsEnable),
    .invert (firstOutputInvert),
    .level  (carrierLevel),
    .pinOut (firstDriverOut),
    .pinOe  (firstDriverOe)
  );

  rtd_pin_drive u_second (
    .clk    (sys_clk),
    .rstN   (rstN),
    .mode   (driverClockMode),
    .enable (driverOutputsEnable),
    .invert (secondOutputInvert),
    .level  (carrierLevel),
    .pinOut (secondDriverOut),
    .pinOe  (secondDriverOe)
  );

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  logic [4:0] boostTicksQ;
  logic [3:0] boostLenQ;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      boostTicksQ <= 5'h00;
      boostLenQ   <= 4'h0;
    end else if (osStateQ != RTD_OS_BOOST) begin
      boostTicksQ <= 5'h00;
      boostLenQ   <= overshootLength;
    end else if (carrierTick) begin
      boostTicksQ <= boostTicksQ + 5'h01;
    end
  end

  property p_second_invert;
    driverOutputsEnable && driverClockMode == RTD_CM_PP
      |=> secondDriverOe && secondDriverOut == $past(carrierLevel ^ secondOutputInvert);
  endproperty
  a_second_invert: assert property (p_second_invert) else $error("second output polarity wrong");

  property p_first_invert;
    driverOutputsEnable && driverClockMode == RTD_CM_PP
      |=> firstDriverOe && firstDriverOut == $past(carrierLevel ^ firstOutputInvert);
  endproperty
  a_first_invert: assert property (p_first_invert) else $error("first output polarity wrong");

  property p_enable_gate;
    !driverOutputsEnable |=> !firstDriverOe && !secondDriverOe;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("outputs driven while disabled");

  property p_fixed_levels;
    driverOutputsEnable && driverClockMode == RTD_CM_HIGH
      |=> firstDriverOut && firstDriverOe && secondDriverOut && secondDriverOe;
  endproperty
  a_fixed_levels: assert property (p_fixed_levels) else $error("fixed high mode not applied");

  property p_trim_path;
    !carrierMax |=> carrierLevelTrimQ == $past(carrierAmplitudeQ[7:6]);
  endproperty
  a_trim_path: assert property (p_trim_path) else $error("carrier trim not forwarded");

  property p_max_override;
    carrierMax |=> carrierMaxQ && carrierLevelTrimQ == 2'h0;
  endproperty
  a_max_override: assert property (p_max_override) else $error("maximum carrier not overriding");

  property p_mod_invert;
    modulationSourceSelect == RTD_SRC_NONE && osStateQ == RTD_OS_IDLE
      |=> modulationQ == $past(modulationInvert);
  endproperty
  a_mod_invert: assert property (p_mod_invert) else $error("idle modulation polarity wrong");

  property p_mod_source;
    modulationSourceSelect == RTD_SRC_EXT && osStateQ == RTD_OS_IDLE
      |=> modulationQ == $past(externalSignalInput ^ modulationInvert);
  endproperty
  a_mod_source: assert property (p_mod_source) else $error("external source not selected");

  property p_boost_length;
    osStateQ == RTD_OS_BOOST ##1 osStateQ != RTD_OS_BOOST |-> boostTicksQ == {1'b0, boostLenQ};
  endproperty
  a_boost_length: assert property (p_boost_length) else $error("overshoot length wrong");

  property p_first_timer;
    osStateQ == RTD_OS_WAIT && carrierTick && osCntQ == 4'h1 |=> osStateQ == RTD_OS_BOOST;
  endproperty
  a_first_timer: assert property (p_first_timer) else $error("first timer did not hand over");

  property p_residual;
    ##1 residualCarrierQ == $past(carrierAmplitudeQ[4:0]);
  endproperty
  a_residual: assert property (p_residual) else $error("residual carrier not forwarded");

  property p_load_trim;
    ##1 loadCurrentTrimQ == $past(loadCurrentOvershootQ[3:0]);
  endproperty
  a_load_trim: assert property (p_load_trim) else $error("load trim not forwarded");

  property p_reserved;
    regs.wrEn && regs.wrIdx == `RTD_IDX_DRV |=> driverOutputModeQ[5:4] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits stored");

  c_boost:   cover property (osStateQ == RTD_OS_WAIT ##[1:300] osStateQ == RTD_OS_BOOST);
  c_od:      cover property (driverOutputsEnable && driverClockMode == RTD_CM_OD ##1 firstDriverOe);
  c_env:     cover property (modulationSourceSelect == RTD_SRC_ENV && modSignal);
  c_bad:     cover property (clockModeBad);
endmodule : rtd_top

// *** bench/rtd_antenna_model.sv ***
// Antenna network model seen from the two driver pins
module rtd_antenna_model (
  // Clock
  input  wire logic clk,
  // Driver pins
  input  wire logic out1,
  input  wire logic oe1,
  input  wire logic out2,
  input  wire logic oe2,
  // Wire levels
  output logic      wire1,
  output logic      wire2
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastFirst_q = 1'b0;
  logic lastSecond_q = 1'b0;
  always_ff @(posedge clk) begin
    if (oe1) lastFirst_q <= out1;
    if (oe2) lastSecond_q <= out2;
  end
  // No pull on the coil, so a floating pin must not look like its old value
  assign wire1 = oe1 ? out1 : ~lastFirst_q;
  assign wire2 = oe2 ? out2 : ~lastSecond_q;
endmodule : rtd_antenna_model

// *** bench/tb_rf_transmitter_driver_config.sv ***
// Self-checking bench for the transmitter driver configuration bank
module tb_rf_transmitter_driver_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, carrierLevel, carrierTick;
  logic internalTransmitEnvelope, externalSignalInput, firstDriverOut, firstDriverOe, secondDriverOut;
  logic secondDriverOe, carrierMaxQ, modulationQ, overshootActiveQ, wire1, wire2;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rd;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, loadCurrentTrimQ;
  logic [1:0]  s_axi_bresp, s_axi_rresp, carrierLevelTrimQ, rsp;
  logic [4:0]  residualCarrierQ;
  int          fail_count = 0;
  int          total_checks = 0;
  rtd_top dut_u (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrierLevel, .carrierTick,
    .internalTransmitEnvelope, .externalSignalInput, .firstDriverOut, .firstDriverOe, .secondDriverOut,
    .secondDriverOe, .carrierMaxQ, .carrierLevelTrimQ, .residualCarrierQ, .loadCurrentTrimQ, .modulationQ,
    .overshootActiveQ);
  rtd_antenna_model ant_u (.clk(sys_clk), .out1(firstDriverOut), .oe1(firstDriverOe), .out2(secondDriverOut),
    .oe2(secondDriverOe), .wire1, .wire2);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic late(input int n);
    if (n >= 60) begin
      chk(8'h00, 8'h01, "bus wait ran out");
      stop_test();
    end
  endtask : late
  // Master holds each channel until its own ready, response ready until valid
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    late(n);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    late(n);
  endtask : axr
  task automatic wset(input logic [7:0] a, input logic [7:0] d);
    axw(a, d, rsp);
    repeat (3) @(posedge sys_clk);
  endtask : wset
  task automatic t_regs;
    logic [7:0] adr [4] = '{8'ha0, 8'ha4, 8'ha8, 8'hac};
    logic [7:0] msk [4] = '{8'hcf, 8'hdf, 8'hff, 8'hff};
    for (int i = 0; i < 4; i++) begin
      axr(adr[i], rd, rsp);
      chk(rd, 8'h00, "reset value");
      axw(adr[i], 8'hff, rsp);
      axr(adr[i], rd, rsp);
      chk(rd, msk[i], "reserved bits");
    end
    axw(8'h10, 8'h55, rsp);
    chk({6'h00, rsp}, 8'h02, "unmapped write");
    axr(8'h00, rd, rsp);
    chk({6'h00, rsp}, 8'h02, "unmapped read");
  endtask : t_regs
  task automatic t_analog;
    wset(8'ha8, 8'h00);
    wset(8'ha4, 8'hff);
    chk({6'h00, carrierLevelTrimQ}, 8'h03, "trim");
    chk({3'h0, residualCarrierQ}, 8'h1f, "residual");
    wset(8'ha8, 8'h08);
    chk({7'h00, carrierMaxQ}, 8'h01, "max");
    chk({6'h00, carrierLevelTrimQ}, 8'h00, "trim ignored");
    wset(8'hac, 8'ha5);
    chk({4'h0, loadCurrentTrimQ}, 8'h05, "load trim");
  endtask : t_analog
  task automatic t_pins;
    logic [2:0] md [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [1:0] ex [4] = '{2'b00, 2'b10, 2'b11, 2'b10};
    carrierLevel <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wset(8'ha0, {i[2], i[1], 2'b00, i[0], 3'h5});
      chk({7'h00, firstDriverOe}, {7'h00, i[0]}, "first enable");
      chk({7'h00, secondDriverOe}, {7'h00, i[0]}, "second enable");
      if (i[0]) begin
        chk({7'h00, firstDriverOut}, {7'h00, ~i[1]}, "first invert");
        chk({7'h00, wire2}, {7'h00, ~i[2]}, "second invert");
      end
    end
    carrierLevel <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wset(8'ha0, {5'h01, md[i]});
      chk({7'h00, firstDriverOe}, {7'h00, ex[i][1]}, "mode enable");
      if (ex[i][1]) chk({7'h00, firstDriverOut}, {7'h00, ex[i][0]}, "mode level");
    end
  endtask : t_pins
  task automatic t_mod;
    internalTransmitEnvelope <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i[2] && (i[1:0] == 2'h0 || i[1:0] == 2'h3)) continue;
      wset(8'ha8, {5'h00, i[2], i[1:0]});
      chk({7'h00, modulationQ}, {7'h00, (i[1:0] == 2'h1) ^ i[2]}, "source");
    end
    // External input high, envelope low, so a wrong pick shows
    internalTransmitEnvelope <= 1'b0;
    externalSignalInput <= 1'b1;
    wset(8'ha8, 8'h02);
    chk({7'h00, modulationQ}, 8'h01, "external source");
    axr(8'hc0, rd, rsp);
    chk(rd, 8'h01, "status word");
  endtask : t_mod
  task automatic t_boost;
    int cnt = 0;
    int firstSeen = 0;
    wset(8'ha8, 8'h31);
    internalTransmitEnvelope <= 1'b0;
    wset(8'hac, 8'h20);
    // Carrier tick every other cycle, so lengths count ticks not cycles
    carrierTick <= 1'b0;
    internalTransmitEnvelope <= 1'b1;
    for (int k = 1; k <= 20; k++) begin
      @(posedge sys_clk);
      carrierTick <= k[0];
      if (overshootActiveQ === 1'b1) begin
        cnt++;
        if (firstSeen == 0) firstSeen = k;
      end
    end
    chk(8'(cnt), 8'h06, "boost length");
    chk(8'(firstSeen), 8'h06, "first timer delay");
  endtask : t_boost
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {carrierLevel, internalTransmitEnvelope, externalSignalInput} = '0;
    carrierTick = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h1;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_analog();
    t_pins();
    t_mod();
    t_boost();
    stop_test();
  end
endmodule : tb_rf_transmitter_driver_config
